// file: design/sei_eeprom_dev.sv
// sei_eeprom_dev: two-wire slave front end of a 32 KB serial eeprom.
// assumes: the bus clock comes from the master and stops between frames;
// clk runs free and only times the internal write cycle.
`timescale 1ns/10ps
`default_nettype none
module sei_eeprom_dev #(
  parameter logic [3:0] TYPE_CODE = sei_pkg::TYPE_CODE_DFLT,
  parameter int TWR_CYC = sei_pkg::TWR_CYC
) (
  // system
  input wire logic clk,
  input wire logic sys_rst,
  // straps and protect
  input wire logic chip_select_bit_zero,
  input wire logic chip_select_bit_one,
  input wire logic chip_select_bit_two,
  input wire logic write_protect,
  // status
  output logic write_busy,
  // bus
  sei_link_if.device link
);
  localparam int CW = $clog2(TWR_CYC + 1);

  // ----------------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------------
  // every byte, erased at start
  logic [7:0] mem_q [0:sei_pkg::MEM_BYTES-1] = '{default: sei_pkg::ERASED_BYTE};

  sei_pkg::sei_dev_state_e state_q;
  logic [3:0] cnt_q, strap_s;
  logic [7:0] sr_q, tx_q, rx_byte, rd_byte;
  logic oe_q, rd_q, wp_ok_q, wr_pend_q, samp_q;
  logic [sei_pkg::MEM_ADDR_W-1:0] addr_q;
  logic start_tgl_q, stop_tgl_q, start_seen_q;
  logic busy_s, addr_hit, stop_s, wr_pend_s, stop_seen_q;
  logic [CW-1:0] busy_cnt_q;

  // ----------------------------------------------------------------------
  // condition detection on data edges
  // ----------------------------------------------------------------------
  // own drive moves only with scl low, so it never counts here
  // start edge
  always_ff @(negedge link.sda or posedge sys_rst) begin
    if (sys_rst) begin
      start_tgl_q <= 1'b0;
    end else if (link.scl) begin
      start_tgl_q <= !start_tgl_q;
    end
  end

  always_ff @(posedge link.sda or posedge sys_rst) begin
    if (sys_rst) begin
      stop_tgl_q <= 1'b0;
    end else if (link.scl) begin
      stop_tgl_q <= !stop_tgl_q;
    end
  end

  sei_sync #(
    .W(5)
  ) u_scl_sync (
    .clk(link.scl),
    .rst(sys_rst),
    .d({chip_select_bit_two, chip_select_bit_one, chip_select_bit_zero,
        write_protect, write_busy}),
    .q({strap_s, busy_s})
  );

  always_ff @(posedge link.scl or posedge sys_rst) begin
    if (sys_rst) begin
      samp_q <= 1'b1;
    end else begin
      samp_q <= link.sda;
    end
  end

  assign rx_byte = {sr_q[6:0], samp_q};
  assign rd_byte = mem_q[addr_q];
  assign addr_hit = (rx_byte[7:4] == TYPE_CODE)
                    && (rx_byte[3:1] == strap_s[3:1]) && !busy_s;

  // start toggle read raw: stable since clock high; a sync loses bit one
  // drive after falling clock
  always_ff @(negedge link.scl or posedge sys_rst) begin
    if (sys_rst) begin
      state_q <= sei_pkg::DST_IDLE;
      cnt_q <= 4'h0;
      sr_q <= 8'h00;
      tx_q <= 8'h00;
      oe_q <= 1'b0;
      rd_q <= 1'b0;
      wp_ok_q <= 1'b0;
      wr_pend_q <= 1'b0;
      addr_q <= '0;
      start_seen_q <= 1'b0;
    end else if (start_tgl_q != start_seen_q) begin
      start_seen_q <= start_tgl_q;
      state_q <= sei_pkg::DST_DEVADDR;
      cnt_q <= 4'h0;
      oe_q <= 1'b0;
      wr_pend_q <= 1'b0;
    end else if (state_q == sei_pkg::DST_IDLE) begin
      oe_q <= 1'b0;
    end else if (cnt_q != sei_pkg::ACK_SLOT) begin
      sr_q <= rx_byte;
      cnt_q <= cnt_q + 4'h1;
      if (cnt_q != sei_pkg::LAST_DATA_BIT) begin
        if (state_q == sei_pkg::DST_RDATA) begin
          oe_q <= !tx_q[7];
          tx_q <= {tx_q[6:0], 1'b0};
        end
      end else begin
        case (state_q)
          sei_pkg::DST_DEVADDR: begin
            if (addr_hit) begin
              oe_q <= 1'b1;
              rd_q <= rx_byte[0];
            end else begin
              state_q <= sei_pkg::DST_IDLE;
              oe_q <= 1'b0;
            end
          end
          sei_pkg::DST_ADDRHI: begin
            addr_q[14:8] <= rx_byte[6:0];
            oe_q <= 1'b1;
          end
          sei_pkg::DST_ADDRLO: begin
            addr_q[7:0] <= rx_byte;
            oe_q <= 1'b1;
          end
          sei_pkg::DST_WDATA: begin
            if (wp_ok_q) begin
              mem_q[addr_q] <= rx_byte;
              oe_q <= 1'b1;
              wr_pend_q <= 1'b1;
              addr_q[sei_pkg::PAGE_OFS_W-1:0] <=
                addr_q[sei_pkg::PAGE_OFS_W-1:0] + 6'h01;
            end else begin
              state_q <= sei_pkg::DST_IDLE;
              oe_q <= 1'b0;
            end
          end
          default: begin
            oe_q <= 1'b0;
          end
        endcase
      end
    end else begin
      cnt_q <= 4'h0;
      oe_q <= 1'b0;
      case (state_q)
        sei_pkg::DST_DEVADDR: begin
          if (rd_q) begin
            state_q <= sei_pkg::DST_RDATA;
            oe_q <= !rd_byte[7];
            tx_q <= {rd_byte[6:0], 1'b0};
            addr_q <= addr_q + 15'h0001;
          end else begin
            state_q <= sei_pkg::DST_ADDRHI;
          end
        end
        sei_pkg::DST_ADDRHI: begin
          state_q <= sei_pkg::DST_ADDRLO;
        end
        sei_pkg::DST_ADDRLO: begin
          state_q <= sei_pkg::DST_WDATA;
          wp_ok_q <= !strap_s[0];
        end
        sei_pkg::DST_WDATA: begin
          state_q <= sei_pkg::DST_WDATA;
        end
        sei_pkg::DST_RDATA: begin
          if (!samp_q) begin
            oe_q <= !rd_byte[7];
            tx_q <= {rd_byte[6:0], 1'b0};
            addr_q <= addr_q + 15'h0001;
          end else begin
            state_q <= sei_pkg::DST_IDLE;
          end
        end
        default: begin
          state_q <= sei_pkg::DST_IDLE;
        end
      endcase
    end
  end

  assign link.sda_d_o = 1'b0;
  assign link.sda_d_oe = oe_q;

  // ----------------------------------------------------------------------
  // system clock domain: internal write cycle
  // ----------------------------------------------------------------------
  // both levels are still between frames, so the plain sync is coherent
  sei_sync #(
    .W(2)
  ) u_clk_sync (
    .clk(clk),
    .rst(sys_rst),
    .d({stop_tgl_q, wr_pend_q}),
    .q({stop_s, wr_pend_s})
  );

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      stop_seen_q <= 1'b0;
      write_busy <= 1'b0;
      busy_cnt_q <= '0;
    end else begin
      stop_seen_q <= stop_s;
      if ((stop_s != stop_seen_q) && wr_pend_s) begin
        write_busy <= 1'b1;
        busy_cnt_q <= CW'(TWR_CYC - 1);
      end else if (busy_cnt_q != '0) begin
        busy_cnt_q <= busy_cnt_q - CW'(1);
      end else begin
        write_busy <= 1'b0;
      end
    end
  end
endmodule : sei_eeprom_dev
`default_nettype wire

// file: design/sei_pkg.sv
// sei_pkg: shared constants and types for the two-wire eeprom link.
// assumes: system clock of 40 ns; both ends and the bench import nothing.
package sei_pkg;

  // ----------------------------------------------------------------------
  // clocking and timing
  // ----------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 40;
  // internal write cycle, longest time: rounds down
  localparam longint TWR_NS = 5000000;
  localparam int TWR_CYC = int'(TWR_NS / CLK_PERIOD_NS);
  // quarter of a bus clock period, least time: rounds up
  localparam int QTR_NS = 300;
  localparam int QTR_CYC = (QTR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ----------------------------------------------------------------------
  // memory geometry and bus framing
  // ----------------------------------------------------------------------
  localparam int MEM_ADDR_W = 15;
  localparam int MEM_BYTES = 32768;
  localparam int PAGE_OFS_W = 6;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;
  localparam logic [3:0] LAST_DATA_BIT = 4'h7;
  localparam logic [3:0] ACK_SLOT = 4'h8;
  // memory-type code: value is arbitrary
  localparam logic [3:0] TYPE_CODE_DFLT = 4'h5;

  // ----------------------------------------------------------------------
  // state and command encodings
  // ----------------------------------------------------------------------
  typedef enum logic [5:0] {
    DST_IDLE    = 6'h01,
    DST_DEVADDR = 6'h02,
    DST_ADDRHI  = 6'h04,
    DST_ADDRLO  = 6'h08,
    DST_WDATA   = 6'h10,
    DST_RDATA   = 6'h20
  } sei_dev_state_e;

  typedef enum logic [3:0] {
    MST_IDLE  = 4'h1,
    MST_START = 4'h2,
    MST_BYTE  = 4'h4,
    MST_STOP  = 4'h8
  } sei_mst_state_e;

  typedef enum logic [1:0] {
    OP_START = 2'h0,
    OP_WRITE = 2'h1,
    OP_READ  = 2'h2,
    OP_STOP  = 2'h3
  } sei_op_e;

endpackage : sei_pkg

// file: design/sei_link_if.sv
// sei_link_if: the two-wire bus between bus master and eeprom device.
// assumes: both ends only pull low; the wire resolves to high otherwise.
`timescale 1ns/10ps
`default_nettype none
interface sei_link_if;
  logic scl;
  logic sda;
  logic sda_m_o;
  logic sda_m_oe;
  logic sda_d_o;
  logic sda_d_oe;

  // open-drain wire with pull-up
  assign sda = !((sda_m_oe && !sda_m_o) || (sda_d_oe && !sda_d_o));

  modport master (output scl, output sda_m_o, output sda_m_oe, input sda);
  modport device (input scl, output sda_d_o, output sda_d_oe, input sda);
endinterface : sei_link_if
`default_nettype wire

// file: design/sei_sync.sv
// sei_sync: two-flop level synchroniser, W bits wide.
// assumes: each bit is a slow level; no bus coherence is promised.
`timescale 1ns/10ps
`default_nettype none
module sei_sync #(
  parameter int W = 1
) (
  // clocking
  input wire logic clk,
  input wire logic rst,
  // level in and out
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_q <= '0;
      q <= '0;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule : sei_sync
`default_nettype wire

// file: design/sei_bus_master.sv
// sei_bus_master: byte-level two-wire master, makes the bus clock.
// assumes: the user issues start, bytes, stop in a legal frame order.
`timescale 1ns/10ps
`default_nettype none
module sei_bus_master #(
  parameter logic [3:0] TYPE_CODE = sei_pkg::TYPE_CODE_DFLT,
  parameter int QTR_CYC = sei_pkg::QTR_CYC
) (
  // system
  input wire logic clk,
  input wire logic sys_rst,
  // command
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic [1:0] cmd_op,
  input wire logic [2:0] cmd_sel,
  input wire logic cmd_rd,
  input wire logic [7:0] cmd_data,
  input wire logic cmd_last,
  // response
  output logic rsp_valid,
  output logic [7:0] rsp_data,
  output logic rsp_nack,
  // bus
  sei_link_if.master link
);
  sei_pkg::sei_mst_state_e state_q;
  logic [7:0] qcnt_q;
  logic [1:0] ph_q;
  logic [3:0] bit_q;
  logic [8:0] tx_q;
  logic [7:0] rx_q;
  logic scl_q;
  logic oe_q;
  logic sda_s;
  logic tick;

  sei_sync #(
    .W(1)
  ) u_sda_sync (
    .clk(clk),
    .rst(sys_rst),
    .d(link.sda),
    .q(sda_s)
  );

  assign tick = (qcnt_q == 8'(QTR_CYC - 1));

  // ----------------------------------------------------------------------
  // quarter-period divider for the bus clock
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      qcnt_q <= 8'h00;
      ph_q <= 2'h0;
    end else if (state_q == sei_pkg::MST_IDLE || tick) begin
      qcnt_q <= 8'h00;
      ph_q <= (state_q == sei_pkg::MST_IDLE) ? 2'h0 : ph_q + 2'h1;
    end else begin
      qcnt_q <= qcnt_q + 8'h01;
    end
  end

  // ----------------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_q <= sei_pkg::MST_IDLE;
      bit_q <= 4'h0;
      tx_q <= 9'h1FF;
      rx_q <= 8'h00;
      scl_q <= 1'b1;
      oe_q <= 1'b0;
      cmd_ready <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_data <= 8'h00;
      rsp_nack <= 1'b0;
    end else begin
      rsp_valid <= 1'b0;
      case (state_q)
        sei_pkg::MST_IDLE: begin
          cmd_ready <= 1'b1;
          bit_q <= 4'h0;
          if (cmd_valid && cmd_ready) begin
            cmd_ready <= 1'b0;
            case (cmd_op)
              sei_pkg::OP_START: begin
                tx_q <= {TYPE_CODE, cmd_sel, cmd_rd, 1'b1};
                state_q <= sei_pkg::MST_START;
              end
              sei_pkg::OP_WRITE: begin
                tx_q <= {cmd_data, 1'b1};
                state_q <= sei_pkg::MST_BYTE;
              end
              sei_pkg::OP_READ: begin
                tx_q <= {8'hFF, cmd_last};
                state_q <= sei_pkg::MST_BYTE;
              end
              default: begin
                state_q <= sei_pkg::MST_STOP;
              end
            endcase
          end
        end
        sei_pkg::MST_START: begin
          if (tick) begin
            case (ph_q)
              2'h0: oe_q <= 1'b0;
              2'h1: scl_q <= 1'b1;
              2'h2: oe_q <= 1'b1;
              default: begin
                scl_q <= 1'b0;
                state_q <= sei_pkg::MST_BYTE;
              end
            endcase
          end
        end
        sei_pkg::MST_BYTE: begin
          if (tick) begin
            case (ph_q)
              // data moves only while clock low
              2'h0: oe_q <= !tx_q[8];
              2'h1: scl_q <= 1'b1;
              2'h2: scl_q <= 1'b1;
              default: begin
                scl_q <= 1'b0;
                tx_q <= {tx_q[7:0], 1'b1};
                rx_q <= {rx_q[6:0], sda_s};
                bit_q <= bit_q + 4'h1;
                if (bit_q == sei_pkg::ACK_SLOT) begin
                  rsp_valid <= 1'b1;
                  rsp_data <= rx_q;
                  rsp_nack <= sda_s;
                  state_q <= sei_pkg::MST_IDLE;
                end
              end
            endcase
          end
        end
        sei_pkg::MST_STOP: begin
          if (tick) begin
            case (ph_q)
              2'h0: oe_q <= 1'b1;
              2'h1: scl_q <= 1'b1;
              2'h2: oe_q <= 1'b0;
              default: begin
                rsp_valid <= 1'b1;
                rsp_nack <= 1'b0;
                state_q <= sei_pkg::MST_IDLE;
              end
            endcase
          end
        end
        default: begin
          state_q <= sei_pkg::MST_IDLE;
        end
      endcase
    end
  end

  assign link.scl = scl_q;
  assign link.sda_m_o = 1'b0;
  assign link.sda_m_oe = oe_q;
endmodule : sei_bus_master
`default_nettype wire

// file: tb/sei_link_asserts.sv
// sei_link_asserts: protocol checks on the two-wire link.
// assumes: one clk domain; scl is made from clk by the bus master.
`timescale 1ns/10ps
`default_nettype none
module sei_link_asserts #(
  parameter int TWR_CYC = 400,
  parameter int QTR_CYC = 4
) (
  // system
  input wire logic clk,
  input wire logic sys_rst,
  // link
  input wire logic scl,
  input wire logic sda,
  input wire logic sda_m_o,
  input wire logic sda_m_oe,
  input wire logic sda_d_o,
  input wire logic sda_d_oe,
  // status
  input wire logic write_busy
);
  logic [19:0] busy_cnt_q;
  logic [15:0] hi_cnt_q;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  // ----------------------------------------------------------------
  // helper counters
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      busy_cnt_q <= '0;
    end else if (write_busy) begin
      busy_cnt_q <= busy_cnt_q + 20'h1;
    end else begin
      busy_cnt_q <= '0;
    end
  end

  // saturates, so a long idle bus never wraps back to zero
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      hi_cnt_q <= '0;
    end else if (!scl) begin
      hi_cnt_q <= '0;
    end else if (hi_cnt_q != 16'hFFFF) begin
      hi_cnt_q <= hi_cnt_q + 16'h1;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  a_drive_on_low: assert property (
    $changed(sda_d_oe) |-> !scl)
    else $error("device drive changed while scl high");
  a_no_fight_high: assert property (
    sda_d_oe && sda_m_oe |-> !scl)
    else $error("both ends pull the data line while scl high");
  a_cond_line_free: assert property (
    scl && $past(scl) && $changed(sda_m_oe) |->
      !sda_d_oe && !$past(sda_d_oe))
    else $error("master condition while device holds the line");
  a_ack_on_wire: assert property (
    $rose(sda_d_oe) |-> ##[1:40] (scl && !sda))
    else $error("device low not seen at next scl high");
  a_start_by_master: assert property (
    scl && $past(scl) && $fell(sda) |-> sda_m_oe && !sda_d_oe)
    else $error("start not made by master");
  a_stop_by_master: assert property (
    scl && $past(scl) && $rose(sda) |-> !$past(sda_d_oe))
    else $error("device released line with scl high");
  a_busy_no_ack: assert property (
    write_busy |-> !sda_d_oe)
    else $error("device drove line during write cycle");
  a_busy_after_stop: assert property (
    $rose(write_busy) |-> scl && sda)
    else $error("write cycle began on a busy bus");
  a_busy_length: assert property (
    $fell(write_busy) |-> busy_cnt_q >= TWR_CYC &&
      busy_cnt_q <= TWR_CYC + 1)
    else $error("write cycle length wrong");
  a_idle_released: assert property (
    hi_cnt_q > 3 * QTR_CYC |-> !sda_d_oe)
    else $error("device holds line on idle bus");

  cover property ($rose(write_busy));
  cover property ($rose(sda_d_oe));
  cover property (scl && $past(scl) && $rose(sda));
endmodule : sei_link_asserts
`default_nettype wire

// file: tb/serial_eeprom_i2c_slave_test.sv
// serial_eeprom_i2c_slave_test: master and eeprom joined on one link.
// assumes: short write cycle and quarter counts set below.
`timescale 1ns/10ps
`default_nettype none
module serial_eeprom_i2c_slave_test;
  localparam int TWR = 400;
  localparam int QTR = 4;
  localparam logic [2:0] SEL = 3'h5;
  logic clk, sys_rst, cmd_valid, cmd_rd, cmd_last, wp, write_busy;
  logic cmd_ready, rsp_valid, rsp_nack, nak;
  logic [1:0] cmd_op;
  logic [2:0] cmd_sel, pins;
  logic [7:0] cmd_data, rsp_data, got;
  int failures, num_checks, polls;

  sei_link_if link_bus ();
  sei_eeprom_dev #(.TWR_CYC(TWR)) sei_eeprom_dev_inst (.clk(clk),
    .sys_rst(sys_rst), .chip_select_bit_zero(pins[0]),
    .chip_select_bit_one(pins[1]), .chip_select_bit_two(pins[2]),
    .write_protect(wp), .write_busy(write_busy), .link(link_bus));
  sei_bus_master #(.QTR_CYC(QTR)) sei_bus_master_inst (.clk(clk),
    .sys_rst(sys_rst), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .cmd_op(cmd_op), .cmd_sel(cmd_sel), .cmd_rd(cmd_rd),
    .cmd_data(cmd_data), .cmd_last(cmd_last), .rsp_valid(rsp_valid),
    .rsp_data(rsp_data), .rsp_nack(rsp_nack), .link(link_bus));
  sei_link_asserts #(.TWR_CYC(TWR), .QTR_CYC(QTR)) sei_link_asserts_inst (
    .clk(clk), .sys_rst(sys_rst), .scl(link_bus.scl), .sda(link_bus.sda),
    .sda_m_o(link_bus.sda_m_o), .sda_m_oe(link_bus.sda_m_oe),
    .sda_d_o(link_bus.sda_d_o), .sda_d_oe(link_bus.sda_d_oe),
    .write_busy(write_busy));

  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : summarize

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // request held until the edge that samples cmd_ready high
  task automatic op(input logic [1:0] o, input logic [7:0] d,
                    input logic last);
    int n = 0;
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_op <= o;
    cmd_data <= d;
    cmd_sel <= d[3:1];
    cmd_rd <= d[0];
    cmd_last <= last;
    do begin
      @(posedge clk);
      n++;
    end while (cmd_ready !== 1'b1 && n < 50);
    if (n >= 50) failures++;
    cmd_valid <= 1'b0;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (rsp_valid !== 1'b1 && n < 1000);
    if (n >= 1000) failures++;
    got = rsp_data;
    nak = rsp_nack;
  endtask : op

  task automatic set_addr(input logic [15:0] a);
    op(sei_pkg::OP_START, {4'h0, SEL, 1'b0}, 1'b0);
    check({7'h0, nak}, 8'h00);
    op(sei_pkg::OP_WRITE, a[15:8], 1'b0);
    check({7'h0, nak}, 8'h00);
    op(sei_pkg::OP_WRITE, a[7:0], 1'b0);
    check({7'h0, nak}, 8'h00);
  endtask : set_addr

  task automatic rd_at(input logic [15:0] a, input logic [23:0] exp,
                       input int cnt);
    set_addr(a);
    op(sei_pkg::OP_START, {4'h0, SEL, 1'b1}, 1'b0);
    check({7'h0, nak}, 8'h00);
    for (int i = 0; i < cnt; i++) begin
      op(sei_pkg::OP_READ, 8'h00, i == cnt - 1);
      check(got, exp[23 - 8 * i -: 8]);
    end
    op(sei_pkg::OP_STOP, 8'h00, 1'b0);
  endtask : rd_at

  task automatic end_wr(input logic exp_busy, input logic wait_low);
    logic seen = 1'b0;
    int n;
    op(sei_pkg::OP_STOP, 8'h00, 1'b0);
    for (n = 0; n < 20; n++) begin
      @(posedge clk);
      seen |= write_busy;
    end
    check({7'h0, seen}, {7'h0, exp_busy});
    n = 0;
    while (wait_low && write_busy !== 1'b0 && n < 2 * TWR) begin
      @(posedge clk);
      n++;
    end
    if (wait_low && n >= 2 * TWR) failures++;
  endtask : end_wr

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // runs well past the expected span of about 9300 cycles
  initial begin
    repeat (40000) @(posedge clk);
    failures++;
    summarize();
  end

  initial begin
    sys_rst = 1'b1;
    cmd_valid = 1'b0;
    cmd_op = 2'h0;
    cmd_sel = 3'h0;
    cmd_rd = 1'b0;
    cmd_data = 8'h00;
    cmd_last = 1'b0;
    wp = 1'b0;
    pins = SEL;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    // top address bit must not matter
    rd_at(16'h8010, 24'hFF0000, 1);
    $display("test erased read done");
    set_addr(16'h0010);
    op(sei_pkg::OP_WRITE, 8'hA5, 1'b0);
    check({7'h0, nak}, 8'h00);
    end_wr(1'b1, 1'b0);
    op(sei_pkg::OP_START, {4'h0, SEL, 1'b1}, 1'b0);
    check({7'h0, nak}, 8'h01);
    polls = 0;
    while (nak === 1'b1 && polls < 20) begin
      op(sei_pkg::OP_STOP, 8'h00, 1'b0);
      op(sei_pkg::OP_START, {4'h0, SEL, 1'b1}, 1'b0);
      polls++;
    end
    check({7'h0, nak}, 8'h00);
    op(sei_pkg::OP_READ, 8'h00, 1'b1);
    check(got, 8'hFF);
    op(sei_pkg::OP_STOP, 8'h00, 1'b0);
    rd_at(16'h0010, 24'hA50000, 1);
    $display("test byte write done");
    set_addr(16'h003E);
    for (int i = 0; i < 3; i++) begin
      op(sei_pkg::OP_WRITE, 8'(24'h112233 >> (16 - 8 * i)), 1'b0);
      check({7'h0, nak}, 8'h00);
    end
    end_wr(1'b1, 1'b1);
    rd_at(16'h003E, 24'h1122FF, 3);
    rd_at(16'h7FFF, 24'hFF33FF, 3);
    $display("test page wrap done");
    for (int s = 0; s < 8; s++) begin
      op(sei_pkg::OP_START, {4'h0, 3'(s), 1'b0}, 1'b0);
      check({7'h0, nak}, {7'h0, 3'(s) != SEL});
      op(sei_pkg::OP_STOP, 8'h00, 1'b0);
    end
    $display("test select done");
    wp <= 1'b1;
    set_addr(16'h0010);
    op(sei_pkg::OP_WRITE, 8'h3C, 1'b0);
    check({7'h0, nak}, 8'h01);
    end_wr(1'b0, 1'b1);
    wp <= 1'b0;
    rd_at(16'h0010, 24'hA50000, 1);
    $display("test protect done");
    summarize();
  end
endmodule : serial_eeprom_i2c_slave_test
`default_nettype wire
